// >>> hdl/adc_conv_ctrl.sv
// Converter control block with APB register slave
//
// Chosen here: register access over APB.
`include "adc_ctrl_regs.svh"
`default_nettype none
module adc_conv_ctrl (
  // Clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST_B,
  // APB slave
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [11:0]           PADDR,
  input  wire logic [31:0]           PWDATA,
  input  wire logic [3:0]            PSTRB,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // Analog converter
  output logic                       CONV_POWER_ENABLE,
  output logic [`NUM_CHANNELS-1:0]   ANALOG_INPUT_SEL,
  output logic                       SAMPLE_EN,
  output logic                       CONVERT_EN,
  input  wire logic [11:0]           CONVERSION_RESULT_IN,
  // Interrupt
  output logic                       IRQ
);
  adc_ctrl_pkg::converter_control_t ctrl_r;
  adc_ctrl_pkg::converter_control_t ctrl_nxt;
  adc_ctrl_pkg::conv_state_t        state_r;
  adc_ctrl_pkg::conv_state_t        state_nxt;

  logic [2:0]  sample_cfg_r;
  logic [2:0]  sample_cfg_nxt;
  logic        irq_mask_r;
  logic        irq_mask_nxt;
  logic [11:0] result_r;
  logic [11:0] result_nxt;
  logic [11:0] result_meta_r;
  logic [11:0] result_sync_r;
  logic        sample_en_r;
  logic        sample_en_nxt;
  logic        convert_en_r;
  logic        convert_en_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;

  logic        timer_load;
  logic [5:0]  timer_val;
  logic        timer_expired;

  logic        setup_phase;
  logic        access_done;
  logic        wr_lane0;
  logic [7:0]  reg_index;
  logic        addr_ok;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_mask;
  logic        wr_cfg;
  logic        start_ok;
  logic        finish;

  localparam logic [5:0] CONV_CYC = 6'(`CONV_CYCLES);

  // True when the address lands on a mapped register word
  function automatic logic reg_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    reg_mapped = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) &&
                 ((idx == `IDX_CONV_CONTROL) || (idx == `IDX_RESULT_LOW) ||
                  (idx == `IDX_RESULT_HIGH)  || (idx == `IDX_IRQ_STATUS) ||
                  (idx == `IDX_IRQ_MASK)     || (idx == `IDX_SAMPLE_CFG));
  endfunction : reg_mapped

  // Sample window length in clocks from the window code
  function automatic logic [5:0] sample_cycles(input logic [2:0] code);
    case (code)
      3'h4:    sample_cycles = `SAMPLE_CYC_3;
      3'h5:    sample_cycles = `SAMPLE_CYC_6;
      3'h6:    sample_cycles = `SAMPLE_CYC_16;
      3'h7:    sample_cycles = `SAMPLE_CYC_32;
      default: sample_cycles = `SAMPLE_CYC_3;
    endcase
  endfunction : sample_cycles

  // Bus decode
  assign setup_phase = PSEL && !PENABLE;
  assign access_done = PSEL && PENABLE && pready_r;
  assign reg_index   = PADDR[9:2];
  assign addr_ok     = reg_mapped(PADDR);
  assign wr_lane0    = access_done && PWRITE && PSTRB[0] && addr_ok;
  assign wr_ctrl     = wr_lane0 && (reg_index == `IDX_CONV_CONTROL);
  assign wr_status   = wr_lane0 && (reg_index == `IDX_IRQ_STATUS);
  assign wr_mask     = wr_lane0 && (reg_index == `IDX_IRQ_MASK);
  assign wr_cfg      = wr_lane0 && (reg_index == `IDX_SAMPLE_CFG);

  // Trigger needs power and an idle converter
  assign start_ok = wr_ctrl && PWDATA[`BIT_TRIGGER] &&
                    PWDATA[`BIT_POWER_ENABLE] &&
                    (state_r == adc_ctrl_pkg::ST_IDLE);
  assign finish   = (state_r == adc_ctrl_pkg::ST_CONVERT) && timer_expired &&
                    ctrl_r.power_enable;

  // APB answer, zero wait states
  always_comb begin
    pready_nxt  = setup_phase;
    pslverr_nxt = setup_phase && !addr_ok;
    prdata_nxt  = prdata_r;
    if (setup_phase) begin
      prdata_nxt = 32'h0000_0000;
      if (addr_ok && !PWRITE) begin
        case (reg_index)
          `IDX_CONV_CONTROL: begin
            prdata_nxt[7:0] = {ctrl_r.power_enable, 1'b0,
                               ctrl_r.done_flag, ctrl_r.input_channel_select};
          end
          `IDX_RESULT_LOW: begin
            prdata_nxt[7:0] = {result_r[3:0], 4'h0};
          end
          `IDX_RESULT_HIGH: begin
            prdata_nxt[7:0] = result_r[11:4];
          end
          `IDX_IRQ_STATUS: begin
            prdata_nxt[`BIT_STATUS_DONE] = ctrl_r.done_flag;
          end
          `IDX_IRQ_MASK: begin
            prdata_nxt[`BIT_MASK_DONE] = irq_mask_r;
          end
          `IDX_SAMPLE_CFG: begin
            prdata_nxt[`SAMPLE_CFG_LSB +: 3] = sample_cfg_r;
          end
          default: begin
            prdata_nxt = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Control, mask, window and done flag
  always_comb begin
    ctrl_nxt         = ctrl_r;
    ctrl_nxt.trigger = 1'b0;
    irq_mask_nxt     = irq_mask_r;
    sample_cfg_nxt   = sample_cfg_r;
    if (wr_ctrl) begin
      ctrl_nxt.power_enable         = PWDATA[`BIT_POWER_ENABLE];
      ctrl_nxt.input_channel_select = PWDATA[4:0];
      if (!PWDATA[`BIT_DONE_FLAG]) begin
        ctrl_nxt.done_flag = 1'b0;
      end
    end
    if (wr_status && PWDATA[`BIT_STATUS_DONE]) begin
      ctrl_nxt.done_flag = 1'b0;
    end
    if (start_ok) begin
      ctrl_nxt.done_flag = 1'b0;
    end
    if (finish) begin
      ctrl_nxt.done_flag = 1'b1;
    end
    if (wr_mask) begin
      irq_mask_nxt = PWDATA[`BIT_MASK_DONE];
    end
    if (wr_cfg) begin
      sample_cfg_nxt = PWDATA[`SAMPLE_CFG_LSB +: 3];
    end
    irq_nxt = ctrl_nxt.done_flag && irq_mask_nxt;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      ctrl_r       <= `CONV_CONTROL_RESET;
      irq_mask_r   <= 1'b0;
      sample_cfg_r <= `SAMPLE_CFG_RESET;
      irq_r        <= 1'b0;
    end else begin
      ctrl_r       <= ctrl_nxt;
      irq_mask_r   <= irq_mask_nxt;
      sample_cfg_r <= sample_cfg_nxt;
      irq_r        <= irq_nxt;
    end
  end

  // Result input synchroniser
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      result_meta_r <= 12'h000;
      result_sync_r <= 12'h000;
    end else begin
      result_meta_r <= CONVERSION_RESULT_IN;
      result_sync_r <= result_meta_r;
    end
  end

  // Sample then convert sequencer
  always_comb begin
    state_nxt      = state_r;
    timer_load     = 1'b0;
    timer_val      = CONV_CYC;
    result_nxt     = result_r;
    case (state_r)
      adc_ctrl_pkg::ST_IDLE: begin
        if (start_ok) begin
          state_nxt  = adc_ctrl_pkg::ST_SAMPLE;
          timer_load = 1'b1;
          timer_val  = sample_cycles(sample_cfg_r);
        end
      end
      adc_ctrl_pkg::ST_SAMPLE: begin
        if (timer_expired) begin
          state_nxt  = adc_ctrl_pkg::ST_CONVERT;
          timer_load = 1'b1;
          timer_val  = CONV_CYC;
        end
      end
      adc_ctrl_pkg::ST_CONVERT: begin
        if (timer_expired) begin
          state_nxt  = adc_ctrl_pkg::ST_IDLE;
          result_nxt = result_sync_r;
        end
      end
      default: begin
        state_nxt = adc_ctrl_pkg::ST_IDLE;
      end
    endcase
    if (!ctrl_nxt.power_enable) begin
      state_nxt  = adc_ctrl_pkg::ST_IDLE;
      result_nxt = result_r;
    end
    sample_en_nxt  = (state_nxt == adc_ctrl_pkg::ST_SAMPLE);
    convert_en_nxt = (state_nxt == adc_ctrl_pkg::ST_CONVERT);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state_r      <= adc_ctrl_pkg::ST_IDLE;
      result_r     <= 12'h000;
      sample_en_r  <= 1'b0;
      convert_en_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      result_r     <= result_nxt;
      sample_en_r  <= sample_en_nxt;
      convert_en_r <= convert_en_nxt;
    end
  end

  phase_timer u_phase_timer (
    .clk      (CORE_CLK),
    .rst_b    (RST_B),
    .load     (timer_load),
    .load_val (timer_val),
    .expired  (timer_expired)
  );

  channel_decode u_channel_decode (
    .clk       (CORE_CLK),
    .rst_b     (RST_B),
    .enable    (ctrl_r.power_enable),
    .sel       (ctrl_r.input_channel_select),
    .switch_on (ANALOG_INPUT_SEL)
  );

  assign PRDATA            = prdata_r;
  assign PREADY            = pready_r;
  assign PSLVERR           = pslverr_r;
  assign CONV_POWER_ENABLE = ctrl_r.power_enable;
  assign SAMPLE_EN         = sample_en_r;
  assign CONVERT_EN        = convert_en_r;
  assign IRQ               = irq_r;
endmodule : adc_conv_ctrl
`default_nettype wire

// >>> pkg/adc_ctrl_regs.svh
// Register indexes, field positions, reset values and timing counts
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
`define IDX_CONV_CONTROL   8'had
`define IDX_RESULT_LOW     8'hae
`define IDX_RESULT_HIGH    8'haf
`define IDX_IRQ_STATUS     8'hb0
`define IDX_IRQ_MASK       8'hb1
`define IDX_SAMPLE_CFG     8'hb5
`define BIT_POWER_ENABLE   7
`define BIT_TRIGGER        6
`define BIT_DONE_FLAG      5
`define BIT_STATUS_DONE    0
`define BIT_MASK_DONE      0
`define SAMPLE_CFG_LSB     2
`define CONV_CONTROL_RESET 8'h00
`define SAMPLE_CFG_RESET   3'h0
`define CLOCK_PERIOD_NS    50
`define CONV_TIME_NS       950
`define CONV_CYCLES        ((`CONV_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SAMPLE_CYC_3       6'h03
`define SAMPLE_CYC_6       6'h06
`define SAMPLE_CYC_16      6'h10
`define SAMPLE_CYC_32      6'h20
`define NUM_CHANNELS       13
`define QUARTER_SUPPLY_SEL 5'h1f
`define LAST_EXT_SEL       5'h0b
`endif

// >>> pkg/adc_ctrl_pkg.sv
// Types shared by the converter control block
`default_nettype none
package adc_ctrl_pkg;
  typedef struct packed {
    logic       power_enable;
    logic       trigger;
    logic       done_flag;
    logic [4:0] input_channel_select;
  } converter_control_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11
  } conv_state_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

// >>> hdl/phase_timer.sv
// Down counter timing the sample and conversion phases
`default_nettype none
module phase_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic       load,
  input  wire logic [5:0] load_val,
  // Status
  output logic            expired
);
  logic [5:0] count_r;
  logic [5:0] count_nxt;
  logic       expired_r;
  logic       expired_nxt;

  always_comb begin
    count_nxt   = count_r;
    if (load) begin
      count_nxt = load_val;
    end else if (count_r != 6'h00) begin
      count_nxt = count_r - 6'h01;
    end
    // Marks the last cycle of a phase, so a phase lasts exactly its count
    expired_nxt = (count_nxt == 6'h01);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_r   <= 6'h00;
      expired_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign expired = expired_r;
endmodule : phase_timer
`default_nettype wire

// >>> hdl/channel_decode.sv
// Registered one-hot analog input selector
`include "adc_ctrl_regs.svh"
`default_nettype none
module channel_decode (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Selection
  input  wire logic                      enable,
  input  wire logic [4:0]                sel,
  // One-hot switch controls
  output logic [`NUM_CHANNELS-1:0]       switch_on
);
  logic [`NUM_CHANNELS-1:0] switch_r;
  logic [`NUM_CHANNELS-1:0] switch_nxt;

  always_comb begin
    switch_nxt = '0;
    if (enable) begin
      if (sel <= `LAST_EXT_SEL) begin
        switch_nxt[sel[3:0]] = 1'b1;
      end else if (sel == `QUARTER_SUPPLY_SEL) begin
        switch_nxt[`NUM_CHANNELS-1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      switch_r <= '0;
    end else begin
      switch_r <= switch_nxt;
    end
  end

  assign switch_on = switch_r;
endmodule : channel_decode
`default_nettype wire

// >>> tb/adc_conv_ctrl_monitor.sv
// Port-level assertions for the converter control block
`include "adc_ctrl_regs.svh"
`default_nettype none
module adc_conv_ctrl_monitor (
  // Clock and reset
  input wire logic                     CORE_CLK,
  input wire logic                     RST_B,
  // APB
  input wire logic                     PSEL,
  input wire logic                     PENABLE,
  input wire logic                     PWRITE,
  input wire logic [11:0]              PADDR,
  input wire logic [31:0]              PWDATA,
  input wire logic [3:0]               PSTRB,
  input wire logic [31:0]              PRDATA,
  input wire logic                     PREADY,
  input wire logic                     PSLVERR,
  // Converter and interrupt
  input wire logic                     CONV_POWER_ENABLE,
  input wire logic [`NUM_CHANNELS-1:0] ANALOG_INPUT_SEL,
  input wire logic                     SAMPLE_EN,
  input wire logic                     CONVERT_EN,
  input wire logic                     IRQ
);
  logic       wr_ok;
  logic       wr_ctl;
  logic       mapped;
  logic       irq_en_r;
  logic [2:0] cfg_r;
  logic [5:0] samp_cnt_r;
  logic [5:0] conv_cnt_r;
  logic [5:0] n_samp;
  assign wr_ok  = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && !PSLVERR;
  assign wr_ctl = wr_ok && PADDR == 12'h2b4;
  assign mapped = PADDR inside {12'h2b4, 12'h2b8, 12'h2bc, 12'h2c0,
                                12'h2c4, 12'h2d4};
  assign n_samp = cfg_r == 3'h5 ? 6'h06 : cfg_r == 3'h6 ? 6'h10 :
                  cfg_r == 3'h7 ? 6'h20 : 6'h03;
  // Shadow of mask, window code and phase lengths
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      irq_en_r   <= 1'b0;
      cfg_r      <= 3'h0;
      samp_cnt_r <= 6'h00;
      conv_cnt_r <= 6'h00;
    end else begin
      if (wr_ok && PADDR == 12'h2c4) irq_en_r <= PWDATA[0];
      if (wr_ok && PADDR == 12'h2d4) cfg_r <= PWDATA[4:2];
      samp_cnt_r <= SAMPLE_EN ? samp_cnt_r + 6'h01 : 6'h00;
      conv_cnt_r <= CONVERT_EN ? conv_cnt_r + 6'h01 : 6'h00;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence start_s;
    wr_ctl && PWDATA[7] && PWDATA[6] && !SAMPLE_EN && !CONVERT_EN;
  endsequence
  apb_ready_a: assert property (setup_s |=> PREADY ##1 !PREADY)
    else $error("ready not one access cycle");
  slave_err_a: assert property (setup_s |=> PSLVERR == !mapped)
    else $error("slave error wrong");
  power_bit_a: assert property (
      wr_ctl |=> CONV_POWER_ENABLE == $past(PWDATA[7]))
    else $error("power bit not applied");
  start_seq_a: assert property (start_s |=> SAMPLE_EN && !CONVERT_EN)
    else $error("trigger did not start");
  no_start_a: assert property (
      wr_ctl && !PWDATA[7] |=> !SAMPLE_EN && !CONVERT_EN)
    else $error("started while unpowered");
  sample_len_a: assert property (
      $fell(SAMPLE_EN) && CONVERT_EN |-> samp_cnt_r == n_samp)
    else $error("sample window length");
  conv_len_a: assert property (
      $fell(CONVERT_EN) && CONV_POWER_ENABLE |-> conv_cnt_r == 6'd19)
    else $error("convert phase length");
  done_irq_a: assert property (
      $fell(CONVERT_EN) && CONV_POWER_ENABLE |-> IRQ == irq_en_r)
    else $error("irq not tied to done");
  onehot_sel_a: assert property ($onehot0(ANALOG_INPUT_SEL))
    else $error("several inputs switched");
  off_sel_a: assert property (
      !CONV_POWER_ENABLE && $past(!CONV_POWER_ENABLE) |->
      ANALOG_INPUT_SEL == '0)
    else $error("switch on while unpowered");
  read_hi_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule : adc_conv_ctrl_monitor
bind adc_conv_ctrl adc_conv_ctrl_monitor adc_conv_ctrl_monitor_i (
  .CORE_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
  .PRDATA, .PREADY, .PSLVERR, .CONV_POWER_ENABLE, .ANALOG_INPUT_SEL,
  .SAMPLE_EN, .CONVERT_EN, .IRQ);
`default_nettype wire

// >>> tb/test_adc_conv_ctrl.sv
// Self-checking bench for the converter control block
`default_nettype none
module test_adc_conv_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic        wr;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  x;
    logic        e;
  } row_t;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic        pslverr;
  logic        pwr;
  logic        samp;
  logic        conv;
  logic        irq;
  logic [12:0] sel;
  logic [11:0] res;
  logic [31:0] q;
  logic        e;
  int          fail_count;
  int          num_checks;
  int          n;
  row_t        rows [12] = '{
    '{1'b0, 12'h2b4, 8'h00, 8'h00, 1'b0},
    '{1'b1, 12'h2b4, 8'h9f, 8'h00, 1'b0},
    '{1'b0, 12'h2b4, 8'h00, 8'h9f, 1'b0},
    '{1'b1, 12'h2d4, 8'h14, 8'h00, 1'b0},
    '{1'b0, 12'h2d4, 8'h00, 8'h14, 1'b0},
    '{1'b1, 12'h2bc, 8'hff, 8'h00, 1'b0},
    '{1'b0, 12'h2bc, 8'h00, 8'h00, 1'b0},
    '{1'b1, 12'h2c4, 8'h01, 8'h00, 1'b0},
    '{1'b0, 12'h2c4, 8'h00, 8'h01, 1'b0},
    '{1'b0, 12'h2a0, 8'h00, 8'h00, 1'b1},
    '{1'b1, 12'h2b6, 8'h00, 8'h00, 1'b1},
    '{1'b0, 12'h2b4, 8'h00, 8'h9f, 1'b0}
  };
  adc_conv_ctrl adc_conv_ctrl_i (
    .CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CONV_POWER_ENABLE(pwr), .ANALOG_INPUT_SEL(sel), .SAMPLE_EN(samp),
    .CONVERT_EN(conv), .CONVERSION_RESULT_IN(res), .IRQ(irq));
  task print_verdict;
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task give_up;
    fail_count++;
    print_verdict();
  endtask : give_up
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task step;
    @(posedge clk);
    #1;
  endtask : step
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 20) give_up();
  endtask : apb
  task rd(input logic [11:0] a, input logic [7:0] x, input string m);
    apb(1'b0, a, 8'h00);
    chk(q, {24'h0, x}, m);
  endtask : rd
  task run_conv(input int ns);
    int k;
    k = 0;
    #1;
    while (samp !== 1'b1 && k < 50) begin
      step();
      k++;
    end
    if (k == 50) give_up();
    n = 0;
    while (samp === 1'b1 && n < 50) begin
      n++;
      step();
    end
    chk(n, ns, "sample clocks");
    n = 0;
    while (conv === 1'b1 && n < 50) begin
      n++;
      step();
    end
    chk(n, 19, "convert clocks");
  endtask : run_conv
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_b      = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    pstrb      = 4'hf;
    res        = 12'ha5c;
    fail_count = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk(e, rows[i].e, "slave error");
      if (!rows[i].wr) chk(q, {24'h0, rows[i].x}, "read");
    end
    for (int c = 0; c < 14; c++) begin
      apb(1'b1, 12'h2b4, c == 13 ? 8'h9f : 8'h80 | 8'(c));
      repeat (2) @(posedge clk);
      chk(sel, c < 12 ? 32'h1 << c : c == 13 ? 32'h1000 : 32'h0,
          "sel");
    end
    apb(1'b1, 12'h2b4, 8'h05);
    repeat (2) @(posedge clk);
    chk({pwr, sel}, 0, "power off");
    apb(1'b1, 12'h2b4, 8'hc3);
    run_conv(6);
    chk(irq, 1, "irq on done");
    rd(12'h2b4, 8'ha3, "ctrl done");
    rd(12'h2bc, 8'ha5, "result high");
    rd(12'h2b8, 8'hc0, "result low");
    apb(1'b1, 12'h2b4, 8'h63);
    n = 0;
    repeat (30) begin
      step();
      n += samp;
    end
    chk(n, 0, "unpowered start");
    rd(12'h2b4, 8'h23, "done kept");
    apb(1'b1, 12'h2c4, 8'h00);
    apb(1'b1, 12'h2d4, 8'h1c);
    apb(1'b1, 12'h2b4, 8'hc3);
    rd(12'h2b4, 8'h83, "done cleared");
    repeat (60) @(posedge clk);
    chk(irq, 0, "masked irq");
    rd(12'h2c0, 8'h01, "status");
    apb(1'b1, 12'h2c4, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1, "unmasked irq");
    pstrb <= 4'he;
    apb(1'b1, 12'h2c4, 8'h00);
    pstrb <= 4'hf;
    rd(12'h2c4, 8'h01, "strobe ignored");
    apb(1'b1, 12'h2c0, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 0, "irq cleared");
    rd(12'h2b4, 8'h83, "ctrl cleared");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk({irq, samp, conv, pwr, sel}, 0, "reset outputs");
    rd(12'h2b4, 8'h00, "reset ctrl");
    apb(1'b1, 12'h2b4, 8'hc3);
    run_conv(3);
    print_verdict();
  end
endmodule : test_adc_conv_ctrl
`default_nettype wire
